// [verilog/mid_pkg.sv]
/*
  Shared constants and types for the 14-bit instruction decoder.
  Assumes a single core clock; addresses are 7-bit file addresses in bank 0.
*/
`default_nettype none
package mid_pkg;

  // Field widths
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int PC_W    = 11;

  // File addresses the decoder looks at
  localparam logic [ADDR_W-1:0] TIMER_COUNT_ADDR = 7'h01;
  localparam logic [ADDR_W-1:0] PORT_A_ADDR      = 7'h05;
  localparam logic [ADDR_W-1:0] PORT_B_ADDR      = 7'h06;

  // Fixed control encodings
  localparam logic [INSTR_W-1:0] ENC_SLEEP     = 14'h0063;
  localparam logic [INSTR_W-1:0] ENC_CLRWDT    = 14'h0064;
  localparam logic [INSTR_W-1:0] ENC_RETFIE    = 14'h0009;
  localparam logic [INSTR_W-1:0] ENC_RETURN    = 14'h0008;

  // Byte-oriented opcode fields (bits 11:8 under group 00)
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR   = 4'h1;
  localparam logic [3:0] OP_SUBWF = 4'h2;
  localparam logic [3:0] OP_DECF  = 4'h3;
  localparam logic [3:0] OP_OR_ACC_FILE = 4'h4;
  localparam logic [3:0] OP_ANDWF = 4'h5;
  localparam logic [3:0] OP_XOR_ACC_FILE = 4'h6;
  localparam logic [3:0] OP_ADDWF = 4'h7;
  localparam logic [3:0] OP_MOVF  = 4'h8;
  localparam logic [3:0] OP_COMF  = 4'h9;
  localparam logic [3:0] OP_INCF  = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC   = 4'hC;
  localparam logic [3:0] OP_RLC   = 4'hD;
  localparam logic [3:0] OP_SWAPF = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;

  // Reset values of the status flags and accumulator
  localparam logic RST_FLAG_TO = 1'b1;
  localparam logic RST_FLAG_PD = 1'b1;
  localparam logic [DATA_W-1:0] RST_ACC = 8'h00;

  // ALU operations
  // Four-state base so the op can travel on a wire port
  typedef enum logic [3:0] {
    MID_ALU_ADD, MID_ALU_SUB, MID_ALU_AND, MID_ALU_OR, MID_ALU_XOR,
    MID_ALU_CLR, MID_ALU_COM, MID_ALU_DEC, MID_ALU_INC, MID_ALU_MOV,
    MID_ALU_ROTL, MID_ALU_ROTR, MID_ALU_SWAP, MID_ALU_BCLR, MID_ALU_BSET,
    MID_ALU_PASSW
  } mid_alu_op_t;

  // Decoded control of one instruction
  typedef struct packed {
    logic useLit;     // Operand B is the literal
    logic wrFile;     // Result to file register
    logic wrAcc;      // Result to accumulator
    logic updC;
    logic updDc;
    logic updZ;
    logic skipZero;   // Skip when result is zero
    logic skipBitClr;
    logic skipBitSet;
    logic branch;     // Load program counter
    logic push;
    logic pop;
    logic sleep;
    logic clrWdt;
    logic retIe;
    logic twoCycle;   // Unconditional second cycle
  } mid_dec_t;

  // Status flags held by the block
  typedef struct packed {
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } mid_flags_t;

  // File write strobe with its data
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mid_file_wr_t;

endpackage
`default_nettype wire

// [verilog/mid_sync.sv]
/*
  Two-flop synchroniser for the port pin levels.
  Assumes pins are asynchronous to clk; output lags by two edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_sync (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Pins in, synced out
  input  wire logic [mid_pkg::DATA_W-1:0] pinIn,
  output var  logic [mid_pkg::DATA_W-1:0] pinOut
);
  import mid_pkg::*;

  logic [DATA_W-1:0] stage1;  // Metastable stage, read only by stage two
  logic [DATA_W-1:0] next_stage1;
  logic [DATA_W-1:0] next_pinOut;

  // One flop pair per pin bit
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    always_comb begin
      next_stage1[i] = pinIn[i];
      next_pinOut[i] = stage1[i];
    end
  end

  // Register both stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 8'h00;
      pinOut <= 8'h00;
    end else begin
      stage1 <= next_stage1;
      pinOut <= next_pinOut;
    end
  end
endmodule
`default_nettype wire

// [verilog/mid_alu.sv]
/*
  Combinational 8-bit ALU with carry, digit carry and zero outputs.
  Assumes the caller picks which flags are kept.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_alu (
  // Operation and operands
  input  wire mid_pkg::mid_alu_op_t         op,
  input  wire logic [mid_pkg::DATA_W-1:0]   src,
  input  wire logic [mid_pkg::DATA_W-1:0]   acc,
  input  wire logic                         cin,
  input  wire logic [2:0]                   bitSel,
  // Results
  output var  logic [mid_pkg::DATA_W-1:0]   res,
  output var  logic                         cOut,
  output var  logic                         dcOut,
  output var  logic                         zOut
);
  import mid_pkg::*;

  logic [8:0] sum;   // Nine bits keep the carry
  logic [4:0] nib;   // Low nibble sum for digit carry

  // Subtraction is src + ~acc + 1, so carry set means no borrow
  always_comb begin
    sum   = 9'h000;
    nib   = 5'h00;
    res   = src;
    cOut  = cin;
    dcOut = 1'b0;
    case (op)
      MID_ALU_ADD: begin
        sum   = {1'b0, src} + {1'b0, acc};
        nib   = {1'b0, src[3:0]} + {1'b0, acc[3:0]};
        res   = sum[7:0];
        cOut  = sum[8];
        dcOut = nib[4];
      end
      MID_ALU_SUB: begin
        sum   = {1'b0, src} + {1'b0, ~acc} + 9'h001;
        nib   = {1'b0, src[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        res   = sum[7:0];
        cOut  = sum[8];
        dcOut = nib[4];
      end
      MID_ALU_AND:   res = src & acc;
      MID_ALU_OR:    res = src | acc;
      MID_ALU_XOR:   res = src ^ acc;
      MID_ALU_CLR:   res = 8'h00;
      MID_ALU_COM:   res = ~src;
      MID_ALU_DEC:   res = src - 8'h01;
      MID_ALU_INC:   res = src + 8'h01;
      MID_ALU_ROTL: begin
        res  = {src[6:0], cin};
        cOut = src[7];
      end
      MID_ALU_ROTR: begin
        res  = {cin, src[7:1]};
        cOut = src[0];
      end
      MID_ALU_SWAP:  res = {src[3:0], src[7:4]};
      MID_ALU_BCLR:  res = src & ~(8'h01 << bitSel);
      MID_ALU_BSET:  res = src | (8'h01 << bitSel);
      MID_ALU_PASSW: res = acc;
      default:       res = src;  // Move passes the operand
    endcase
    zOut = (res == 8'h00);
  end
endmodule
`default_nettype wire

// [verilog/mid_decoder.sv]
/*
  Decode and execution control for a 14-bit instruction word core.
  Holds the accumulator and status flags, drives file writes, branch,
  stack and power control, and inserts the idle second cycle.
  Assumes the datapath returns the addressed file value in the same
  cycle the instruction is presented, and that the fetch stage holds
  the word while instrReady is low.
*/
// Contract
// - Decrement file, skip next when zero
// - Increment file, skip next when zero
// - Rotate left through carry, only carry changes
// - Rotate right through carry, only carry changes
// - OR accumulator with file, update zero
// - XOR accumulator with file, update zero
// - Bit test, skip when bit clear
// - Bit test, skip when bit set
// - OR literal into accumulator, update zero
// - XOR literal into accumulator, update zero
// - Literal minus accumulator, update carry, digit, zero
// - Return with literal, two cycles
// - Standby encoding sets expiry, clears power-down flags
// - Port read-modify-write uses pin levels
// - Timer count write clears assigned prescaler
// - Branch or true skip adds idle cycle
`timescale 1ns/1ps
`default_nettype none
module mid_decoder (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           nrst,
  // Instruction from fetch
  input  wire logic [mid_pkg::INSTR_W-1:0]    instrWord,
  input  wire logic                           instrValid,
  output logic                                instrReady,
  // Datapath operand and pins
  input  wire logic [mid_pkg::DATA_W-1:0]     fileData,
  input  wire logic [mid_pkg::DATA_W-1:0]     portPins,
  input  wire logic                           prescalerOnTimer,
  // File write
  output mid_pkg::mid_file_wr_t               fileWr,
  // Accumulator and flags
  output logic [mid_pkg::DATA_W-1:0]          accW,
  output mid_pkg::mid_flags_t                 flags,
  // Program flow
  output logic                                flushNext,
  output logic                                pcLoad,
  output logic [mid_pkg::PC_W-1:0]            pcTarget,
  output logic                                stackPush,
  output logic                                stackPop,
  output logic                                intEnableSet,
  // Power and timer control
  output logic                                sleepReq,
  output logic                                wdtClear,
  output logic                                prescalerClear
);
  import mid_pkg::*;
  typedef enum {MID_ST_EXEC, MID_ST_IDLE} mid_state_t;
  mid_state_t        state;        // Execute or idle second cycle
  mid_state_t        next_state;
  mid_dec_t          dec;          // Decoded current word
  mid_alu_op_t       aluOp;
  logic [DATA_W-1:0] pinSync;      // Pins after two flops
  logic [DATA_W-1:0] srcVal;       // File or pin or literal operand
  logic [DATA_W-1:0] aluRes;
  logic              aluC;
  logic              aluDc;
  logic              aluZ;
  logic              taken;        // Word accepted this cycle
  logic              isPort;
  logic              bitVal;       // Selected bit of the operand
  logic              doSkip;
  logic              nextTwo;
  // Next values of the registered outputs
  logic              next_instrReady;
  mid_file_wr_t      next_fileWr;
  logic [DATA_W-1:0] next_accW;
  mid_flags_t        next_flags;
  logic              next_flushNext;
  logic              next_pcLoad;
  logic [PC_W-1:0]   next_pcTarget;
  logic              next_stackPush;
  logic              next_stackPop;
  logic              next_intEnableSet;
  logic              next_sleepReq;
  logic              next_wdtClear;
  logic              next_prescalerClear;
  // Port addresses are read back from pins
  function automatic logic portAddr(input logic [ADDR_W-1:0] a);
    portAddr = (a == PORT_A_ADDR) || (a == PORT_B_ADDR);
  endfunction
  // Full table decode of one word
  function automatic mid_dec_t decodeInstr(input logic [INSTR_W-1:0] iw);
    mid_dec_t d;
    d = '0;
    case (iw[13:12])
      2'b00: begin
        d.wrFile = iw[7];
        d.wrAcc  = !iw[7];
        case (iw[11:8])
          OP_MOVWF: begin
            d.wrAcc  = 1'b0;
            d.clrWdt = (iw == ENC_CLRWDT);
            d.sleep  = (iw == ENC_SLEEP);
            d.retIe  = (iw == ENC_RETFIE);
            d.pop    = (iw == ENC_RETFIE) || (iw == ENC_RETURN);
            d.twoCycle = d.pop;
          end
          OP_CLR, OP_DECF, OP_ANDWF, OP_MOVF, OP_COMF, OP_INCF:
            d.updZ = 1'b1;
          OP_OR_ACC_FILE, OP_XOR_ACC_FILE: d.updZ = 1'b1;
          OP_SUBWF, OP_ADDWF: begin
            d.updC  = 1'b1;
            d.updDc = 1'b1;
            d.updZ  = 1'b1;
          end
          OP_DECSZ, OP_INCSZ: d.skipZero = 1'b1;
          OP_RRC, OP_RLC: d.updC = 1'b1;
          default: ;                                           // Swap: no flags
        endcase
      end
      2'b01: begin
        d.wrFile     = !iw[11];                                // Clear or set bit
        d.skipBitClr = (iw[11:10] == 2'b10);
        d.skipBitSet = (iw[11:10] == 2'b11);
      end
      2'b10: begin
        d.branch   = 1'b1;
        d.push     = !iw[11];
        d.twoCycle = 1'b1;
      end
      default: begin
        d.useLit = 1'b1;
        d.wrAcc  = 1'b1;
        if (iw[11:10] == 2'b01) begin
          d.pop      = 1'b1;
          d.twoCycle = 1'b1;
        end else if (iw[11:10] == 2'b11 || iw[11:9] == 3'b110) begin
          d.updC  = 1'b1;
          d.updDc = 1'b1;
          d.updZ  = 1'b1;
        end else if (iw[11:10] == 2'b10) begin
          d.updZ = 1'b1;
        end
      end
    endcase
    decodeInstr = d;
  endfunction
  // Pin synchroniser
  mid_sync u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .pinIn  (portPins),
    .pinOut (pinSync)
  );

  // Operand selection and ALU op choice
  always_comb begin
    dec    = decodeInstr(instrWord);
    isPort = portAddr(instrWord[6:0]) && !dec.useLit;
    srcVal = dec.useLit ? instrWord[7:0] : (isPort ? pinSync : fileData);
    bitVal = srcVal[instrWord[9:7]];
    aluOp  = MID_ALU_MOV;
    case (instrWord[13:12])
      2'b00: begin
        case (instrWord[11:8])
          OP_MOVWF: aluOp = MID_ALU_PASSW;
          OP_CLR:   aluOp = MID_ALU_CLR;
          OP_SUBWF: aluOp = MID_ALU_SUB;
          OP_DECF:  aluOp = MID_ALU_DEC;
          OP_OR_ACC_FILE: aluOp = MID_ALU_OR;
          OP_ANDWF: aluOp = MID_ALU_AND;
          OP_XOR_ACC_FILE: aluOp = MID_ALU_XOR;
          OP_ADDWF: aluOp = MID_ALU_ADD;
          OP_COMF:  aluOp = MID_ALU_COM;
          OP_INCF:  aluOp = MID_ALU_INC;
          OP_DECSZ: aluOp = MID_ALU_DEC;
          OP_RRC:   aluOp = MID_ALU_ROTR;
          OP_RLC:   aluOp = MID_ALU_ROTL;
          OP_SWAPF: aluOp = MID_ALU_SWAP;
          OP_INCSZ: aluOp = MID_ALU_INC;
          default:  aluOp = MID_ALU_MOV;
        endcase
      end
      2'b01:   aluOp = instrWord[10] ? MID_ALU_BSET : MID_ALU_BCLR;
      2'b10:   aluOp = MID_ALU_MOV;
      default: begin
        case (instrWord[11:9])
          3'b100:  aluOp = instrWord[8] ? MID_ALU_AND : MID_ALU_OR;
          3'b101:  aluOp = MID_ALU_XOR;
          3'b110:  aluOp = MID_ALU_SUB;
          3'b111:  aluOp = MID_ALU_ADD;
          default: aluOp = MID_ALU_MOV;                        // Move or return literal
        endcase
      end
    endcase
  end
  // Shared ALU
  mid_alu u_alu (
    .op     (aluOp),
    .src    (srcVal),
    .acc    (accW),
    .cin    (flags.c),
    .bitSel (instrWord[9:7]),
    .res    (aluRes),
    .cOut   (aluC),
    .dcOut  (aluDc),
    .zOut   (aluZ)
  );
  // Execution: results, flags and flow control
  always_comb begin
    taken   = instrValid && instrReady && (state == MID_ST_EXEC);
    doSkip  = (dec.skipZero && aluZ) || (dec.skipBitClr && !bitVal)
              || (dec.skipBitSet && bitVal);
    nextTwo = taken && (dec.twoCycle || doSkip);
    next_state          = nextTwo ? MID_ST_IDLE : MID_ST_EXEC;
    next_instrReady     = (next_state == MID_ST_EXEC);
    next_fileWr         = fileWr;
    next_fileWr.we      = taken && dec.wrFile;
    next_accW           = accW;
    next_flags          = flags;
    next_flushNext      = nextTwo;
    next_pcLoad         = taken && dec.branch;
    next_pcTarget       = pcTarget;
    next_stackPush      = taken && dec.push;
    next_stackPop       = taken && dec.pop;
    next_intEnableSet   = taken && dec.retIe;
    next_sleepReq       = taken && dec.sleep;
    next_wdtClear       = taken && dec.clrWdt;
    // Writes to the timer count clear an attached prescaler
    next_prescalerClear = taken && dec.wrFile
                          && (instrWord[6:0] == TIMER_COUNT_ADDR)
                          && prescalerOnTimer;
    if (taken) begin
      if (dec.wrFile) begin
        next_fileWr.addr = instrWord[6:0];
        next_fileWr.data = aluRes;
      end
      if (dec.wrAcc) next_accW = aluRes;
      if (dec.branch) next_pcTarget = instrWord[10:0];         // Jump target
      if (dec.updC) next_flags.c = aluC;
      if (dec.updDc) next_flags.digit_carry_flag = aluDc;
      if (dec.updZ) next_flags.z = aluZ;
      if (dec.sleep) begin
        next_flags.watchdog_expiry_flag = 1'b1;
        next_flags.power_down_flag      = 1'b0;
      end
      if (dec.clrWdt) begin
        next_flags.watchdog_expiry_flag = 1'b1;
        next_flags.power_down_flag      = 1'b1;
      end
    end
  end
  // Register everything
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state          <= MID_ST_EXEC;
      instrReady     <= 1'b0;
      fileWr         <= '0;
      accW           <= RST_ACC;
      flags          <= {RST_FLAG_TO, RST_FLAG_PD, 3'b000};
      flushNext      <= 1'b0;
      pcLoad         <= 1'b0;
      pcTarget       <= 11'h000;
      stackPush      <= 1'b0;
      stackPop       <= 1'b0;
      intEnableSet   <= 1'b0;
      sleepReq       <= 1'b0;
      wdtClear       <= 1'b0;
      prescalerClear <= 1'b0;
    end else begin
      state          <= next_state;
      instrReady     <= next_instrReady;
      fileWr         <= next_fileWr;
      accW           <= next_accW;
      flags          <= next_flags;
      flushNext      <= next_flushNext;
      pcLoad         <= next_pcLoad;
      pcTarget       <= next_pcTarget;
      stackPush      <= next_stackPush;
      stackPop       <= next_stackPop;
      intEnableSet   <= next_intEnableSet;
      sleepReq       <= next_sleepReq;
      wdtClear       <= next_wdtClear;
      prescalerClear <= next_prescalerClear;
    end
  end
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_idle_then_ready;
    !instrReady ##1 instrReady;
  endsequence
  a_decsz_skip_zero: assert property (taken && instrWord[13:8] == 6'h0B && aluZ
    |=> flushNext ##0 s_idle_then_ready) else $error("decrement skip missing");
  a_incsz_skip_zero: assert property (taken && instrWord[13:8] == 6'h0F
    |=> flushNext && ($past(instrWord[7]) ? fileWr.data == 8'h00 : accW == 8'h00))
    else $error("increment skip missing");
  a_rotl_carry_only: assert property (taken && instrWord[13:8] == 6'h0D
    |=> flags.c == $past(srcVal[7]) && $stable(flags.z)) else $error("rotate left flags");
  a_rotr_carry_only: assert property (taken && instrWord[13:8] == 6'h0C
    |=> flags.c == $past(srcVal[0]) && $stable(flags.digit_carry_flag))
    else $error("rotate right flags");
  a_or_zero_flag: assert property (taken && instrWord[13:8] == 6'h04
    |=> flags.z == ($past(srcVal | accW) == 8'h00)) else $error("or zero flag");
  a_xorlit_result: assert property (taken && instrWord[13:9] == 5'b11101
    |=> accW == ($past(accW) ^ $past(srcVal)) && !flushNext)
    else $error("xor literal result");
  a_bit_clear_skip: assert property (taken && instrWord[13:10] == 4'b0110
    && !bitVal |=> flushNext ##0 s_idle_then_ready) else $error("bit clear skip missing");
  a_bit_set_skip: assert property (taken && instrWord[13:10] == 4'b0111
    |=> flushNext == $past(bitVal) && $stable(flags)) else $error("bit set skip");
  a_sleep_flags: assert property (taken && instrWord == ENC_SLEEP
    |=> sleepReq && flags.watchdog_expiry_flag && !flags.power_down_flag)
    else $error("standby flags wrong");
  a_port_pin_source: assert property (taken && isPort && instrWord[13:7] == 7'h11
    |=> fileWr.data == $past(portPins, 3)) else $error("port source not pins");
  a_timer_prescale: assert property (taken && dec.wrFile && prescalerOnTimer
    && instrWord[6:0] == TIMER_COUNT_ADDR |=> prescalerClear && fileWr.we)
    else $error("prescaler not cleared");
  a_branch_two_cycle: assert property (taken && instrWord[13:12] == 2'b10
    |=> pcLoad && pcTarget == $past(instrWord[10:0]) ##0 s_idle_then_ready)
    else $error("branch timing wrong");
  a_retlit_load: assert property (taken && instrWord[13:10] == 4'b1101
    |=> stackPop && accW == $past(instrWord[7:0]) && !instrReady)
    else $error("return literal wrong");
  a_dest_select: assert property (taken && instrWord[13:12] == 2'b00
    && instrWord[11:8] != 4'h0 |=> fileWr.we == $past(instrWord[7])
    && (!fileWr.we || $stable(accW))) else $error("destination wrong");
endmodule
`default_nettype wire

// [tb/mid_dp_model.sv]
/*
  Datapath stand-in: file registers read by address, written by fileWr.
  Assumes the fetch side holds instrWord steady while a word waits.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_dp_model (
  // Clock
  input  wire logic                        clk,
  // Decoder side
  input  wire logic [mid_pkg::INSTR_W-1:0] instrWord,
  input  wire mid_pkg::mid_file_wr_t       fileWr,
  output var  logic [mid_pkg::DATA_W-1:0]  fileData
);
  import mid_pkg::*;
  logic [DATA_W-1:0] mem [128]; // File registers
  // Unwritten cells hold a pattern, so a stale read never looks like zero
  initial for (int i = 0; i < 128; i++) mem[i] = ~i[7:0];
  // Same-cycle read, as the decoder expects
  assign fileData = mem[instrWord[ADDR_W-1:0]];
  // Writes land at the clock edge
  always @(posedge clk) if (fileWr.we) mem[fileWr.addr] <= fileWr.data;
endmodule
`default_nettype wire

// [tb/mid_decoder_tb.sv]
/*
  Self-checking bench for the decoder, one task per scenario.
  Assumes mid_dp_model stands in for the datapath's file registers.
*/
`timescale 1ns/1ps
`default_nettype none
module mid_decoder_tb;
  import mid_pkg::*;
  logic clk, nrst, instrValid, instrReady, preOnTmr; // Drive and handshake
  logic [INSTR_W-1:0] instrWord;
  logic [DATA_W-1:0]  fileData, portPins, accW;
  mid_file_wr_t       fileWr;
  mid_flags_t         flags;
  logic flushNext, pcLoad, stackPop, sleepReq, preClr, stackPush, intEnSet, wdtClr; // Pulses
  logic [PC_W-1:0]    pcTarget;
  int mismatches, check_count;
  mid_decoder DUT (.clk(clk), .nrst(nrst), .instrWord(instrWord),
    .instrValid(instrValid), .instrReady(instrReady), .fileData(fileData),
    .portPins(portPins), .prescalerOnTimer(preOnTmr), .fileWr(fileWr),
    .accW(accW), .flags(flags), .flushNext(flushNext), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .stackPush(stackPush), .stackPop(stackPop),
    .intEnableSet(intEnSet), .sleepReq(sleepReq), .wdtClear(wdtClr),
    .prescalerClear(preClr));
  mid_dp_model dp (.clk(clk), .instrWord(instrWord), .fileWr(fileWr),
    .fileData(fileData));
  // Clock, 10 ns period
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Present a word, wait for ready, return in the answer cycle
  task automatic run(input logic [INSTR_W-1:0] w);
    int n;
    n = 0;
    @(negedge clk);
    instrWord = w;
    instrValid = 1'h1;
    while (instrReady !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(instrReady, 1'h1);
    @(negedge clk);
    instrValid = 1'h0;
  endtask
  task automatic t_skip;
    dp.mem[7'h20] = 8'h01;
    dp.mem[7'h21] = 8'hFF;
    run(14'h0BA0);
    chk(fileWr.we, 1'h1);
    chk(fileWr.data, 8'h00);
    chk(flushNext, 1'h1);
    chk(instrReady, 1'h0);
    run(14'h30AA);
    run(14'h0F21);
    chk(accW, 8'h00);
    chk(fileWr.we, 1'h0);
    chk(flushNext, 1'h1);
  endtask
  task automatic t_rot;
    dp.mem[7'h22] = 8'h81;
    dp.mem[7'h23] = 8'h01;
    run(14'h0D22);
    chk(accW, 8'h02);
    chk(flags, 5'h19);
    run(14'h0C23);
    chk(accW, 8'h80);
    chk(flags, 5'h19);
  endtask
  task automatic t_logic;
    dp.mem[7'h24] = 8'hF0;
    dp.mem[7'h25] = 8'hFF;
    run(14'h300F);
    run(14'h0424);
    chk(accW, 8'hFF);
    run(14'h0625);
    chk(accW, 8'h00);
    chk(flags.z, 1'h1);
  endtask
  task automatic t_bits;
    dp.mem[7'h26] = 8'h08;
    run(14'h19A6);
    chk(flushNext, 1'h0);
    run(14'h1926);
    chk(flushNext, 1'h1);
    run(14'h1DA6);
    chk(flushNext, 1'h1);
    chk(flags, 5'h1D);
  endtask
  task automatic t_lit;
    run(14'h3881);
    chk({accW, 3'h0, flags}, 16'h8119);
    run(14'h3A81);
    chk(flags.z, 1'h1);
    run(14'h3A3C);
    run(14'h3C10);
    chk({accW, 3'h0, flags}, 16'hD418);
  endtask
  task automatic t_flow;
    run(14'h345A);
    chk({accW, stackPop, flushNext, instrReady}, 11'h2D6);
    run(14'h2923);
    chk({pcLoad, pcTarget, flushNext}, 13'h1247);
    run(14'h0063);
    chk({flags.watchdog_expiry_flag, flags.power_down_flag}, 2'h2);
    chk(sleepReq, 1'h1);
    run(14'h0064);
    chk({wdtClr, flags.watchdog_expiry_flag, flags.power_down_flag}, 3'h7);
    run(14'h2005);
    chk({stackPush, pcLoad, pcTarget}, 13'h1805);
    run(14'h0009);
    chk({intEnSet, stackPop, flushNext}, 3'h7);
  endtask
  task automatic t_io;
    dp.mem[7'h06] = 8'hFF;
    run(14'h0886);
    chk({fileWr.addr, fileWr.data}, 15'h06A5);
    preOnTmr = 1'h1;
    run(14'h0181);
    chk(preClr, 1'h1);
    preOnTmr = 1'h0;
    run(14'h0181);
    chk(preClr, 1'h0);
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the fewer than a hundred cycles the tests need
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
  // Reset for 4 cycles, then the scenarios in order
  initial begin
    {nrst, instrValid, preOnTmr} = 3'h0;
    instrWord = 14'h0000;
    portPins = 8'hA5;
    repeat (4) @(posedge clk);
    @(negedge clk) nrst = 1'h1;
    repeat (2) @(negedge clk);
    t_skip();
    t_rot();
    t_logic();
    t_bits();
    t_lit();
    t_flow();
    t_io();
    end_of_test();
  end
endmodule
`default_nettype wire
